// ==== rtl/adc_ctrl_pkg.sv ====
// Constants, register map and types for the converter control block
package adc_ctrl_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CLK = 8'h04;
    localparam logic [7:0] OFF_TRIG = 8'h08;
    localparam logic [7:0] OFF_RESULT = 8'h0C;
    localparam logic [7:0] OFF_FLAG = 8'h10;

    // Field positions
    localparam int EN_BIT = 0;
    localparam int GO_BIT = 1;
    localparam int CHS_LSB = 2;
    localparam int CHS_MSB = 7;
    localparam int CS_LSB = 4;
    localparam int CS_MSB = 6;
    localparam int TRIG_MSB = 4;
    localparam int FLAG_BIT = 0;
    localparam int IE_BIT = 1;

    // Values after reset
    localparam logic [5:0] CHS_RESET = 6'h00;
    localparam logic [2:0] CS_RESET = 3'h0;
    localparam logic [4:0] TRIG_RESET = 5'h00;

    // Channel codes
    localparam logic [5:0] CH_PORTA_BASE = 6'h00;
    localparam logic [5:0] CH_PORTB_BASE = 6'h0C;
    localparam logic [5:0] CH_PORTC_BASE = 6'h10;
    localparam logic [5:0] CH_GND = 6'h3C;
    localparam logic [5:0] CH_TEMP = 6'h3D;
    localparam logic [5:0] CH_DAC = 6'h3E;
    localparam logic [5:0] CH_FVR = 6'h3F;

    // Conversion clock codes
    localparam logic [2:0] CS_DIV2 = 3'h0;
    localparam logic [2:0] CS_DIV8 = 3'h1;
    localparam logic [2:0] CS_DIV32 = 3'h2;
    localparam logic [2:0] CS_DIV4 = 3'h4;
    localparam logic [2:0] CS_DIV16 = 3'h5;
    localparam logic [2:0] CS_DIV64 = 3'h6;
    localparam logic [1:0] CS_RC_LOW = 2'h3;

    // Trigger selector
    localparam logic [4:0] TRIG_NONE = 5'h00;
    localparam int TRIG_COUNT = 17;

    // Timing
    localparam int CLK_NS = 5;
    localparam int RC_TAD_NS = 2000;
    localparam int RC_TAD_CYCLES = RC_TAD_NS / CLK_NS;
    localparam int START_DELAY_CYCLES = 4;
    localparam int CONV_TADS = 12;
    localparam logic [15:0] DIV2_CYCLES = 16'h0002;
    localparam logic [15:0] DIV4_CYCLES = 16'h0004;
    localparam logic [15:0] DIV8_CYCLES = 16'h0008;
    localparam logic [15:0] DIV16_CYCLES = 16'h0010;
    localparam logic [15:0] DIV32_CYCLES = 16'h0020;
    localparam logic [15:0] DIV64_CYCLES = 16'h0040;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_CONV = 2'b10
    } conv_state_t;

endpackage

// ==== rtl/tad_if.sv ====
// Conversion clock tick carrier between control and tick generator
`timescale 1ns/1ps
interface tad_if;
    logic [2:0] clk_sel;
    logic run;
    logic tick;
    logic rc_sel;
    modport gen (input clk_sel, input run, output tick, output rc_sel);
    modport ctl (output clk_sel, output run, input tick, input rc_sel);
endinterface // tad_if

// ==== rtl/tad_tick_gen.sv ====
// Conversion clock period tick generator
`timescale 1ns/1ps
module tad_tick_gen #(
    parameter int RC_CYCLES = adc_ctrl_pkg::RC_TAD_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    tad_if.gen t
);

    logic [15:0] cnt_q;
    logic [15:0] lim;

    // Divider per clock code, RC codes use the dedicated period
    assign t.rc_sel = (t.clk_sel[1:0] == adc_ctrl_pkg::CS_RC_LOW); // see (RQ19)

    always_comb begin
        case (t.clk_sel)
            adc_ctrl_pkg::CS_DIV2: lim = adc_ctrl_pkg::DIV2_CYCLES; // see (RQ19)
            adc_ctrl_pkg::CS_DIV8: lim = adc_ctrl_pkg::DIV8_CYCLES;
            adc_ctrl_pkg::CS_DIV32: lim = adc_ctrl_pkg::DIV32_CYCLES;
            adc_ctrl_pkg::CS_DIV4: lim = adc_ctrl_pkg::DIV4_CYCLES;
            adc_ctrl_pkg::CS_DIV16: lim = adc_ctrl_pkg::DIV16_CYCLES;
            adc_ctrl_pkg::CS_DIV64: lim = adc_ctrl_pkg::DIV64_CYCLES;
            default: lim = 16'(RC_CYCLES);
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst || !t.run) begin
            cnt_q <= 16'h0000;
            t.tick <= 1'b0;
        end else if (cnt_q >= lim - 16'h0001) begin
            cnt_q <= 16'h0000;
            t.tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            t.tick <= 1'b0;
        end
    end

endmodule // tad_tick_gen

// ==== rtl/adc_sleep_trigger_control.sv ====
// Converter control: registers, start/abort, sleep handling, auto trigger
//
// Contract
// (RQ1) Conversion continues in sleep only with the dedicated RC clock selected.
// (RQ2) With RC clock, start waits one extra instruction before converting.
// (RQ3) Completion in sleep with interrupt enabled wakes the device.
// (RQ4) Completion in sleep with interrupt off powers down; enable stays set.
// (RQ5) Sleep with non-RC clock aborts and powers down; enable stays set.
// (RQ6) Rising edge of selected trigger source sets the start bit.
// (RQ7) Seventeen trigger sources: timers, comparators, logic cells, capture units.
// (RQ8) Software waits an acquisition period after changing channel.
// (RQ9) Six-bit channel field in bits 7..2; port A, B, C code ranges.
// (RQ10) Codes 3F, 3E, 3D, 3C select reference, DAC, temperature, ground.
// (RQ11) Reserved channel codes connect nothing to the sample-and-hold.
// (RQ12) Writing one to bit 1 starts; it reads one while converting.
// (RQ13) Hardware clears the start bit on completion.
// (RQ14) Enable bit 0 powers the converter; cleared means no current.
// (RQ15) Software configures, enables, waits acquisition, then starts.
// (RQ16) Software polls the start bit or waits for the interrupt.
// (RQ17) Software clears the complete flag before enabling and after each read.
// (RQ18) Software may keep global interrupts off to resume in line.
// (RQ19) Clock codes x11 pick RC clock; others divide the system clock.
// (RQ20) Completion clears start, sets the flag, loads the result.
// (RQ21) Trigger code 0 is none; 10001, 10000 are timer 5, 3; rising edge.
// (RQ22) Timer overflow triggers coincide with the timer's own flag setting.
// (RQ23) RC start delay is four system clock periods.
// (RQ24) A sleep abort clears the start bit without setting the flag.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module adc_sleep_trigger_control (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_active,
    input wire logic [16:0] trigger_src,
    input wire logic [9:0] sar_result,
    output logic [5:0] mux_select,
    output logic mux_connect,
    output logic converter_powered,
    output logic sample_convert,
    output logic conv_complete_flag,
    output logic wake_request
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    tad_if t ();

    logic [5:0] chs_q;
    logic en_q;
    logic go_q;
    logic [2:0] cs_q;
    logic [4:0] trig_sel_q;
    logic [9:0] result_q;
    logic flag_q;
    logic ie_q;
    logic off_q;
    logic trig_lvl_q;
    logic trig_lvl;
    logic trig_edge;
    logic [1:0] dly_q;
    logic [3:0] tad_cnt_q;
    adc_ctrl_pkg::conv_state_t st_q;
    logic acc;
    logic wr_fire;
    logic ctrl_wr;
    logic sw_go_set;
    logic sw_go_clr;
    logic abort_cond;
    logic go_req;
    logic go_set_ok;
    logic stop_ev;
    logic done_ev;
    logic chan_ok;
    logic [31:0] rdata;
    logic rd_err;

    tad_tick_gen #(
        .RC_CYCLES(adc_ctrl_pkg::RC_TAD_CYCLES)
    ) u_tick (
        .clk(clk),
        .nrst(nrst),
        .t(t)
    );

    assign t.clk_sel = cs_q;
    assign t.run = (st_q == adc_ctrl_pkg::ST_CONV);

    ////////////////////////////////////////////////////////////////////////////
    // APB slave

    assign acc = psel && penable;
    assign wr_fire = acc && pwrite && pready;
    assign ctrl_wr = wr_fire && (paddr == adc_ctrl_pkg::OFF_CTRL);
    assign sw_go_set = ctrl_wr && pwdata[adc_ctrl_pkg::GO_BIT]; // see (RQ12)
    assign sw_go_clr = ctrl_wr && !pwdata[adc_ctrl_pkg::GO_BIT] && go_q;

    always_comb begin
        rdata = 32'h00000000;
        rd_err = 1'b0;
        case (paddr)
            adc_ctrl_pkg::OFF_CTRL: rdata[7:0] = {chs_q, go_q, en_q}; // see (RQ9)
            adc_ctrl_pkg::OFF_CLK: rdata[adc_ctrl_pkg::CS_MSB:adc_ctrl_pkg::CS_LSB] = cs_q;
            adc_ctrl_pkg::OFF_TRIG: rdata[adc_ctrl_pkg::TRIG_MSB:0] = trig_sel_q;
            adc_ctrl_pkg::OFF_RESULT: rdata[9:0] = result_q;
            adc_ctrl_pkg::OFF_FLAG: rdata[1:0] = {ie_q, flag_q};
            default: rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= acc && !pready;
            prdata <= (acc && !pready && !pwrite) ? rdata : 32'h00000000;
            pslverr <= acc && !pready && rd_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_ff @(posedge clk) begin
        if (!nrst) begin
            chs_q <= adc_ctrl_pkg::CHS_RESET;
            en_q <= 1'b0;
        end else if (ctrl_wr) begin
            chs_q <= pwdata[adc_ctrl_pkg::CHS_MSB:adc_ctrl_pkg::CHS_LSB]; // see (RQ9)
            en_q <= pwdata[adc_ctrl_pkg::EN_BIT]; // see (RQ14)
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cs_q <= adc_ctrl_pkg::CS_RESET;
            trig_sel_q <= adc_ctrl_pkg::TRIG_RESET;
            ie_q <= 1'b0;
        end else if (wr_fire) begin
            if (paddr == adc_ctrl_pkg::OFF_CLK) begin
                cs_q <= pwdata[adc_ctrl_pkg::CS_MSB:adc_ctrl_pkg::CS_LSB];
            end
            if (paddr == adc_ctrl_pkg::OFF_TRIG) begin
                trig_sel_q <= pwdata[adc_ctrl_pkg::TRIG_MSB:0];
            end
            if (paddr == adc_ctrl_pkg::OFF_FLAG) begin
                ie_q <= pwdata[adc_ctrl_pkg::IE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Auto trigger

    // Source order by code: 1 tmr4, 2 tmr6, 3 timer_zero, 4 tmr1, 5 tmr2, 6..7 cmp,
    // 8..11 logic cells, 12..15 capture units, 16 tmr3, 17 tmr5
    always_comb begin
        trig_lvl = 1'b0;
        if (trig_sel_q != adc_ctrl_pkg::TRIG_NONE &&
            int'(trig_sel_q) <= adc_ctrl_pkg::TRIG_COUNT) begin // see (RQ21)
            trig_lvl = trigger_src[trig_sel_q - 5'h01]; // see (RQ7) see (RQ22)
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            trig_lvl_q <= 1'b0;
        end else begin
            trig_lvl_q <= trig_lvl;
        end
    end

    assign trig_edge = trig_lvl && !trig_lvl_q; // see (RQ21)

    ////////////////////////////////////////////////////////////////////////////
    // Start bit and power state

    assign abort_cond = sleep_active && !t.rc_sel; // see (RQ1)
    assign go_req = sw_go_set || trig_edge; // see (RQ6)
    assign go_set_ok = go_req && en_q && !off_q && !abort_cond;
    assign stop_ev = abort_cond || sw_go_clr || !en_q;
    assign done_ev = (st_q == adc_ctrl_pkg::ST_CONV) && t.tick &&
                     (tad_cnt_q == 4'(adc_ctrl_pkg::CONV_TADS - 1)) && !stop_ev;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            go_q <= 1'b0;
        end else if (go_set_ok) begin
            go_q <= 1'b1; // see (RQ6) see (RQ12)
        end else if (done_ev || stop_ev) begin
            go_q <= 1'b0; // see (RQ13) see (RQ24) see (RQ5)
        end
    end

    // Converter off while enable still reads set
    always_ff @(posedge clk) begin
        if (!nrst) begin
            off_q <= 1'b0;
        end else if (!sleep_active) begin
            off_q <= 1'b0;
        end else if (abort_cond) begin
            off_q <= 1'b1; // see (RQ5)
        end else if (done_ev && !ie_q) begin
            off_q <= 1'b1; // see (RQ4)
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q <= adc_ctrl_pkg::ST_IDLE;
            dly_q <= 2'h0;
            tad_cnt_q <= 4'h0;
        end else begin
            case (st_q)
                adc_ctrl_pkg::ST_IDLE: begin
                    dly_q <= 2'h0;
                    tad_cnt_q <= 4'h0;
                    if (go_q && !stop_ev && !off_q) begin
                        if (t.rc_sel) begin
                            st_q <= adc_ctrl_pkg::ST_DELAY; // see (RQ2)
                        end else begin
                            st_q <= adc_ctrl_pkg::ST_CONV;
                        end
                    end
                end
                adc_ctrl_pkg::ST_DELAY: begin
                    if (stop_ev) begin
                        st_q <= adc_ctrl_pkg::ST_IDLE;
                    end else if (dly_q == 2'(adc_ctrl_pkg::START_DELAY_CYCLES - 1)) begin
                        st_q <= adc_ctrl_pkg::ST_CONV; // see (RQ23)
                    end else begin
                        dly_q <= dly_q + 2'h1;
                    end
                end
                adc_ctrl_pkg::ST_CONV: begin
                    if (stop_ev) begin
                        st_q <= adc_ctrl_pkg::ST_IDLE; // see (RQ5)
                    end else if (t.tick) begin
                        if (done_ev) begin
                            st_q <= adc_ctrl_pkg::ST_IDLE;
                        end else begin
                            tad_cnt_q <= tad_cnt_q + 4'h1;
                        end
                    end
                end
                default: st_q <= adc_ctrl_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result and completion flag

    always_ff @(posedge clk) begin
        if (!nrst) begin
            result_q <= 10'h000;
        end else if (done_ev || (sw_go_clr && st_q == adc_ctrl_pkg::ST_CONV)) begin
            result_q <= sar_result; // see (RQ20)
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flag_q <= 1'b0;
        end else if (done_ev) begin
            flag_q <= 1'b1; // see (RQ20)
        end else if (wr_fire && paddr == adc_ctrl_pkg::OFF_FLAG &&
                     pwdata[adc_ctrl_pkg::FLAG_BIT]) begin
            flag_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Front end outputs

    always_comb begin
        case (chs_q)
            adc_ctrl_pkg::CH_FVR, adc_ctrl_pkg::CH_DAC,
            adc_ctrl_pkg::CH_TEMP, adc_ctrl_pkg::CH_GND: chan_ok = 1'b1; // see (RQ10)
            default: chan_ok =
                (chs_q >= adc_ctrl_pkg::CH_PORTA_BASE && chs_q <= 6'h02) ||
                (chs_q == 6'h04) || (chs_q == 6'h05) ||
                (chs_q >= adc_ctrl_pkg::CH_PORTB_BASE && chs_q <= 6'h17); // see (RQ11)
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mux_select <= adc_ctrl_pkg::CHS_RESET;
            mux_connect <= 1'b0;
            converter_powered <= 1'b0;
            sample_convert <= 1'b0;
            conv_complete_flag <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            mux_select <= chs_q; // see (RQ9)
            mux_connect <= chan_ok && en_q; // see (RQ11)
            converter_powered <= en_q && !off_q; // see (RQ14) see (RQ4)
            sample_convert <= (st_q == adc_ctrl_pkg::ST_CONV);
            conv_complete_flag <= flag_q;
            wake_request <= done_ev && sleep_active && ie_q; // see (RQ3)
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence delay_hold_s;
        ($rose(st_q == adc_ctrl_pkg::ST_DELAY) && en_q && t.rc_sel) ##0 (!wr_fire)[*4];
    endsequence

    sequence conv_entry_s;
        st_q == adc_ctrl_pkg::ST_CONV;
    endsequence

    rc_start_delay_a: assert property ( // see (RQ2) see (RQ23)
        delay_hold_s |-> (st_q == adc_ctrl_pkg::ST_DELAY) ##1 conv_entry_s)
        else $error("rc start delay not four cycles");

    done_clears_go_a: assert property ( // see (RQ13) see (RQ20)
        done_ev && !go_set_ok |=> !go_q && flag_q && result_q == $past(sar_result))
        else $error("completion did not clear start and set flag");

    sleep_abort_a: assert property ( // see (RQ5) see (RQ24)
        go_q && abort_cond && en_q && !ctrl_wr |=> !go_q && !$rose(flag_q) && en_q && off_q)
        else $error("sleep abort misbehaved");

    trig_sets_go_a: assert property ( // see (RQ6)
        trig_edge && en_q && !off_q && !abort_cond |=> go_q)
        else $error("trigger edge did not set start bit");

    reserved_chan_a: assert property ( // see (RQ11)
        chs_q == 6'h3B || chs_q == 6'h0B || chs_q == 6'h03 |=> !mux_connect)
        else $error("reserved channel connected");

    disabled_off_a: assert property ( // see (RQ14)
        !en_q |=> !converter_powered ##0 (st_q == adc_ctrl_pkg::ST_IDLE))
        else $error("disabled converter still active");

    sleep_pd_a: assert property ( // see (RQ4)
        done_ev && sleep_active && !ie_q |=> off_q ##1 !converter_powered)
        else $error("no power down after sleep conversion");

    sleep_wake_a: assert property ( // see (RQ3)
        done_ev && sleep_active && ie_q |=> wake_request && !off_q)
        else $error("no wake after sleep conversion");

    rc_sleep_run_a: assert property ( // see (RQ1)
        st_q == adc_ctrl_pkg::ST_CONV && sleep_active && t.rc_sel && en_q && !ctrl_wr
        |=> st_q == adc_ctrl_pkg::ST_CONV || flag_q)
        else $error("rc conversion stopped by sleep");

endmodule // adc_sleep_trigger_control

// ==== test/trig_sh_model.sv ====
// Trigger peripherals and sample-and-hold front end model
`timescale 1ns/1ps
module trig_sh_model (
    input wire logic clk,
    input wire logic fire,
    input wire logic [4:0] idx,
    input wire logic sample_convert,
    input wire logic [5:0] mux_select,
    output logic [16:0] trigger_src,
    output logic [9:0] sar_result
);
    logic [1:0] hold_q;
    initial begin
        trigger_src = 17'h00000;
        sar_result = 10'h000;
        hold_q = 2'h0;
    end
    ////////////////////////////////////////
    // Low to high pulse like a peripheral flag setting
    always @(posedge clk) begin
        if (fire) begin
            trigger_src <= 17'h00001 << idx;
            hold_q <= 2'h2;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end else begin
            trigger_src <= 17'h00000;
        end
    end
    // Held sample while converting, toggling otherwise
    always @(posedge clk) begin
        sar_result <= sample_convert ? {4'h9, mux_select} : ~sar_result;
    end
endmodule // trig_sh_model

// ==== test/test_adc_sleep_trigger_control.sv ====
// Testbench for the converter control block
`timescale 1ns/1ps
module test_adc_sleep_trigger_control;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic sleep_active = 1'b0;
    logic fire = 1'b0;
    logic [4:0] idx = 5'h00;
    logic [31:0] prdata;
    logic pready, pslverr, mux_connect, converter_powered;
    logic sample_convert, conv_complete_flag, wake_request;
    logic [16:0] trigger_src;
    logic [9:0] sar_result;
    logic [5:0] mux_select;
    int error_cnt = 0;
    int check_count = 0;
    logic [31:0] rd;
    logic er;
    logic [31:0] seed = 32'h0000E8C2;
    logic [5:0] ech;
    logic [31:0] eres;
    logic [5:0] fixed [4] = '{6'h3B, 6'h0B, 6'h03, 6'h3E};
    int n;
    localparam int ACQ_CYCLES = 8;

    always #2.5 clk = ~clk;

    adc_sleep_trigger_control u_adc_sleep_trigger_control (.clk(clk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_active(sleep_active),
        .trigger_src(trigger_src), .sar_result(sar_result), .mux_select(mux_select),
        .mux_connect(mux_connect), .converter_powered(converter_powered),
        .sample_convert(sample_convert), .conv_complete_flag(conv_complete_flag),
        .wake_request(wake_request));
    trig_sh_model u_trig_sh_model (.clk(clk), .fire(fire), .idx(idx),
        .sample_convert(sample_convert), .mux_select(mux_select),
        .trigger_src(trigger_src), .sar_result(sar_result));
    ////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic ch_ok(input logic [5:0] c);
        return (c <= 6'h05 && c != 6'h03) || (c >= 6'h0C && c <= 6'h17) || c >= 6'h3C;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            error_cnt++;
            final_report();
        end
    endtask
    // Poll the flag, then check status, result and flag pin
    task automatic finish_conv(input logic ie);
        int k;
        k = 0;
        rd = 32'h0;
        while (rd[0] !== 1'b1 && k < 3000) begin
            apb(1'b0, adc_ctrl_pkg::OFF_FLAG, 32'h0);
            k++;
        end
        if (k >= 3000) begin
            error_cnt++;
            final_report();
        end
        chk(conv_complete_flag, 1'b1);
        apb(1'b0, adc_ctrl_pkg::OFF_CTRL, 32'h0);
        chk(rd, {24'h0, ech, 2'b01});
        apb(1'b0, adc_ctrl_pkg::OFF_RESULT, 32'h0);
        chk(rd, eres);
        chk(sample_convert, 1'b0);
        apb(1'b1, adc_ctrl_pkg::OFF_FLAG, {30'h0, ie, 1'b1});
    endtask
    task automatic start;
        apb(1'b1, adc_ctrl_pkg::OFF_CTRL, {24'h0, ech, 2'b01});
        repeat (ACQ_CYCLES) @(posedge clk);
        apb(1'b1, adc_ctrl_pkg::OFF_CTRL, {24'h0, ech, 2'b11});
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 0; a < 5; a++) begin
            apb(1'b0, 8'(a * 4), 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, 8'h14, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, adc_ctrl_pkg::OFF_RESULT, 32'h000003FF);
        apb(1'b0, adc_ctrl_pkg::OFF_RESULT, 32'h0);
        chk(rd, 32'h0);
        // Channel decode, fixed and random codes
        for (int i = 0; i < 12; i++) begin
            ech = (i < 4) ? fixed[i] : 6'(xs());
            apb(1'b1, adc_ctrl_pkg::OFF_CTRL, {24'h0, ech, 2'b01});
            repeat (3) @(posedge clk);
            chk(mux_select, ech);
            chk(mux_connect, ch_ok(ech));
            chk(converter_powered, 1'b1);
        end
        apb(1'b1, adc_ctrl_pkg::OFF_CTRL, 32'h0);
        apb(1'b1, adc_ctrl_pkg::OFF_CTRL, {24'h0, ech, 2'b10});
        apb(1'b0, adc_ctrl_pkg::OFF_CTRL, 32'h0);
        chk(rd, {24'h0, ech, 2'b00});
        chk({mux_connect, converter_powered}, 2'b00);
        // Software start with the divided system clock
        ech = adc_ctrl_pkg::CH_PORTC_BASE;
        eres = {22'h0, 4'h9, ech};
        start();
        apb(1'b0, adc_ctrl_pkg::OFF_CTRL, 32'h0);
        chk(rd, {24'h0, ech, 2'b11});
        chk(sample_convert, 1'b1);
        finish_conv(1'b0);
        // Every trigger source, then no trigger
        for (int c = 1; c <= adc_ctrl_pkg::TRIG_COUNT; c++) begin
            apb(1'b1, adc_ctrl_pkg::OFF_TRIG, 32'(c));
            fire <= 1'b1;
            idx <= 5'(c - 1);
            @(posedge clk);
            fire <= 1'b0;
            finish_conv(1'b0);
        end
        apb(1'b1, adc_ctrl_pkg::OFF_TRIG, 32'h0);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (40) @(posedge clk);
        apb(1'b0, adc_ctrl_pkg::OFF_FLAG, 32'h0);
        chk(rd, 32'h0);
        // Sleep with divided clock aborts
        start();
        sleep_active <= 1'b1;
        repeat (3) @(posedge clk);
        chk(converter_powered, 1'b0);
        apb(1'b0, adc_ctrl_pkg::OFF_CTRL, 32'h0);
        chk(rd, {24'h0, ech, 2'b01});
        apb(1'b0, adc_ctrl_pkg::OFF_FLAG, 32'h0);
        chk(rd, 32'h0);
        sleep_active <= 1'b0;
        // RC clock in sleep, interrupt on
        apb(1'b1, adc_ctrl_pkg::OFF_CLK, 32'h00000030);
        apb(1'b1, adc_ctrl_pkg::OFF_FLAG, 32'h00000003);
        start();
        sleep_active <= 1'b1;
        n = 0;
        while (wake_request !== 1'b1 && n < 8000) begin
            @(posedge clk);
            n++;
        end
        chk(n < 8000, 1'b1);
        if (n >= 8000) begin
            final_report();
        end
        sleep_active <= 1'b0;
        finish_conv(1'b0);
        // RC clock in sleep, interrupt off
        start();
        sleep_active <= 1'b1;
        n = 0;
        while (converter_powered !== 1'b0 && n < 8000) begin
            @(posedge clk);
            n++;
        end
        chk(n < 8000, 1'b1);
        if (n >= 8000) begin
            final_report();
        end
        chk(wake_request, 1'b0);
        apb(1'b0, adc_ctrl_pkg::OFF_CTRL, 32'h0);
        chk(rd, {24'h0, ech, 2'b01});
        apb(1'b0, adc_ctrl_pkg::OFF_FLAG, 32'h0);
        chk(rd, 32'h1);
        sleep_active <= 1'b0;
        final_report();
    end
endmodule // test_adc_sleep_trigger_control
